// >>> bench/remote_ctrl_model.sv
// Remote controller model: issues one decoded command at a time.
// Assumes replies come as one-cycle pulses after the strobe.
`timescale 1ns/1ps
`default_nettype none
module remote_ctrl_model (
   // Clock
   input  wire logic        ref_clk,
   // Replies from the block
   input  wire logic        resp_valid,
   input  wire logic [15:0] resp_data,
   input  wire logic        poll_valid,
   input  wire logic [7:0]  poll_byte,
   input  wire logic        cmd_hold,
   // Decoded strobes and data
   output var  logic [12:0] stb,
   output var  logic [7:0]  cmd_data
);
   initial begin
      stb = 13'h0000;
      cmd_data = 8'h00;
   end

   // One strobe per command, never while held off; a lost reply is a timeout
   task automatic issue(input int code, input logic [7:0] d, input logic want,
                        output logic [15:0] r, output logic ok);
      int n;
      r = 16'hFFFF;
      ok = 1'b0;
      for (n = 0; n < 500 && cmd_hold !== 1'b0; n++) @(negedge ref_clk);
      if (cmd_hold !== 1'b0) return;
      ok = !want;
      stb[code] = 1'b1;
      cmd_data = d;
      @(negedge ref_clk);
      stb = 13'h0000;
      cmd_data = ~d; // Released data must not keep its value
      for (n = 0; n < 500 && !ok; n++) begin
         if (resp_valid === 1'b1 || poll_valid === 1'b1) begin
            ok = 1'b1;
            r = poll_valid ? {8'h00, poll_byte} : resp_data;
         end else begin
            @(negedge ref_clk);
         end
      end
      @(negedge ref_clk); // Gap so strobes never toggle twice in a step
   endtask
endmodule
`default_nettype wire

// >>> bench/sbsr_props.sv
// Port-level assertions for the status byte and service request core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sbsr_props (
   // Clock and reset
   input wire        ref_clk,
   input wire        reset,
   input wire        clk_en,
   // Strobes and device state
   input wire        cls_stb,
   input wire        esr_rd_stb,
   input wire        opc_rd_stb,
   input wire        stb_rd_stb,
   input wire        poll_stb,
   input wire        exec_busy,
   input wire        err_not_empty,
   input wire        msg_avail,
   // Replies and status
   input wire        resp_valid,
   input wire [15:0] resp_data,
   input wire        poll_valid,
   input wire [7:0]  poll_byte,
   input wire [7:0]  service_status_byte,
   input wire        cmd_hold,
   input wire        err_queue_clear
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Status byte bits against their sources
   a_unused_low: assert property (service_status_byte[1:0] == 2'h0)
      else $error("unused status bits set");
   a_errq_bit: assert property (clk_en |=> service_status_byte[2] == $past(err_not_empty))
      else $error("error queue bit wrong");
   a_mav_bit: assert property (clk_en |=> service_status_byte[4] == $past(msg_avail))
      else $error("message bit wrong");
   a_mss_cause: assert property (service_status_byte[6] |->
      |{service_status_byte[7], service_status_byte[5:2]})
      else $error("summary bit without cause");

   // Operation-complete query hold-off; the reset guard hides pre-reset history
   a_hold_start: assert property (opc_rd_stb && clk_en |=> cmd_hold)
      else $error("no hold after query");
   a_hold_busy: assert property (cmd_hold && exec_busy && clk_en |=> cmd_hold)
      else $error("hold dropped while busy");
   a_opc_reply: assert property (!$past(reset) && $fell(cmd_hold) |->
      resp_valid && resp_data == 16'h0001)
      else $error("bad completion reply");

   // Replies one cycle after the strobe
   a_read_answer: assert property ((esr_rd_stb || stb_rd_stb) && clk_en |=>
      resp_valid && resp_data[15:8] == 8'h00)
      else $error("read not answered");
   a_stb_value: assert property (stb_rd_stb && clk_en |=>
      resp_data[7:0] == service_status_byte)
      else $error("status byte reply differs");
   a_poll_reply: assert property (poll_stb && clk_en |=> poll_valid && poll_byte[1:0] == 2'h0)
      else $error("poll not answered");
   a_cls_pulse: assert property (cls_stb && clk_en |=> err_queue_clear)
      else $error("no error queue clear");
endmodule

bind status_byte_service_request sbsr_props sbsr_props_inst (
   .ref_clk, .reset, .clk_en, .cls_stb, .esr_rd_stb, .opc_rd_stb, .stb_rd_stb, .poll_stb,
   .exec_busy, .err_not_empty, .msg_avail, .resp_valid, .resp_data, .poll_valid,
   .poll_byte, .service_status_byte, .cmd_hold, .err_queue_clear
);
`default_nettype wire

// >>> bench/test_status_byte_service_request.sv
// Self-checking bench for the status byte and service request core.
// Assumes the controller model drives all common command strobes.
`timescale 1ns/1ps
`default_nettype none
module test_status_byte_service_request;
   localparam int CLS = 0, ESEW = 1, ESER = 2, ESRR = 3, OPC = 4, OPCR = 5, PSCW = 6;
   localparam int PSCR = 7, SREW = 8, SRER = 9, STBR = 10, POLL = 11, PRE = 12;
   // Inputs, changed on the falling edge
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        clk_en = 1'b1;
   logic        psc_restore = 1'b0;
   logic [7:0]  sre_restore = 8'hFF;
   logic [7:0]  ese_restore = 8'h21;
   logic        grp_wr_stb = 1'b0;
   logic        grp_rd_stb = 1'b0;
   logic [3:0]  grp_sel = 4'h0;
   logic [2:0]  grp_reg = 3'h0;
   logic [15:0] grp_wr_data = 16'h0000;
   logic        exec_busy = 1'b0;
   logic        err_not_empty = 1'b0;
   logic        msg_avail = 1'b0;
   logic [7:0]  std_event_set = 8'h00;
   logic [15:0] oper_cond = 16'h0000;
   logic [15:0] ques_cond = 16'h0000;
   logic [79:0] sub_cond = 80'h0;
   // Outputs and controller strobes
   wire  [12:0] stb;
   wire  [7:0]  cmd_data, poll_byte, service_status_byte;
   wire  [15:0] resp_data, errq_enable;
   wire         resp_valid, poll_valid, srq, cmd_hold, err_queue_clear, psc_flag;
   int          failures = 0;
   int          compares = 0;
   logic [15:0] r;
   logic        ok;

   always #4 ref_clk = ~ref_clk;

   status_byte_service_request #(.NSUB(5)) status_byte_service_request_inst (
      .ref_clk, .reset, .clk_en, .psc_restore, .sre_restore, .ese_restore, .cls_stb(stb[0]),
      .ese_wr_stb(stb[1]), .ese_rd_stb(stb[2]), .esr_rd_stb(stb[3]), .opc_stb(stb[4]),
      .opc_rd_stb(stb[5]), .psc_wr_stb(stb[6]), .psc_rd_stb(stb[7]), .sre_wr_stb(stb[8]),
      .sre_rd_stb(stb[9]), .stb_rd_stb(stb[10]), .poll_stb(stb[11]), .preset_stb(stb[12]),
      .cmd_data, .grp_wr_stb, .grp_rd_stb, .grp_sel, .grp_reg, .grp_wr_data, .exec_busy,
      .err_not_empty, .msg_avail, .std_event_set, .oper_cond, .ques_cond, .sub_cond,
      .resp_valid, .resp_data, .poll_byte, .poll_valid, .service_status_byte, .srq,
      .cmd_hold, .err_queue_clear, .errq_enable, .psc_flag);

   remote_ctrl_model remote_ctrl_model_inst (
      .ref_clk, .resp_valid, .resp_data, .poll_valid, .poll_byte, .cmd_hold, .stb, .cmd_data);

   // Shared helpers
   task automatic report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic cmd(input int c, input logic [7:0] d, input logic want = 1'b0);
      remote_ctrl_model_inst.issue(c, d, want, r, ok);
      if (!ok) begin
         failures++;
         report_and_stop;
      end
   endtask
   task automatic rd(input int c);
      cmd(c, 8'h00, 1'b1);
   endtask
   task automatic grp(input logic wr, input logic [3:0] s, input logic [2:0] g,
                      input logic [15:0] d);
      grp_sel = s;
      grp_reg = g;
      grp_wr_data = d;
      grp_wr_stb = wr;
      grp_rd_stb = !wr;
      wait_n(1);
      grp_wr_stb = 1'b0;
      grp_rd_stb = 1'b0;
      r = resp_data;
      if (!wr) chk("grp valid", {15'h0, resp_valid}, 16'h0001);
      wait_n(1);
   endtask
   task automatic gr(input logic [3:0] s, input logic [2:0] g);
      grp(1'b0, s, g, 16'h0000);
   endtask
   task automatic do_reset(input logic p);
      psc_restore = p;
      reset = 1'b1;
      wait_n(2);
      reset = 1'b0;
      wait_n(1);
   endtask

   // Scenarios
   task automatic t_restore;
      do_reset(1'b0);
      chk("psc", {15'h0, psc_flag}, 16'h0000);
      rd(SRER); chk("sre", r, 16'h00BF);
      rd(ESER); chk("ese", r, 16'h0021);
      do_reset(1'b1);
      rd(PSCR); chk("psc q", r, 16'h0001);
      rd(SRER); chk("sre", r, 16'h0000);
      rd(ESER); chk("ese", r, 16'h0000);
      gr(4'h2, 3'h2); chk("sub en", r, 16'h0000);
      cmd(PSCW, 8'h00); chk("psc", {15'h0, psc_flag}, 16'h0000);
      $display("t_restore done");
   endtask
   task automatic t_enables;
      cmd(SREW, 8'hFF);
      clk_en = 1'b0; // Frozen: this write must be lost
      cmd(SREW, 8'h10);
      clk_en = 1'b1;
      rd(SRER); chk("sre", r, 16'h00BF);
      cmd(ESEW, 8'h55);
      rd(ESER); chk("ese", r, 16'h0055);
      $display("t_enables done");
   endtask
   task automatic t_sbyte;
      cmd(SREW, 8'h00);
      err_not_empty = 1'b1;
      msg_avail = 1'b1;
      wait_n(3);
      chk("sb", service_status_byte, 16'h0014);
      rd(STBR); chk("stb q", r, 16'h0014);
      chk("sb", service_status_byte, 16'h0014);
      cmd(SREW, 8'h10);
      wait_n(3);
      chk("sb", service_status_byte, 16'h0054);
      chk("srq", {15'h0, srq}, 16'h0001);
      rd(POLL); chk("poll", r, 16'h0054);
      chk("srq", {15'h0, srq}, 16'h0000);
      rd(STBR); chk("stb q", r, 16'h0054);
      rd(POLL); chk("poll", r, 16'h0014);
      msg_avail = 1'b0;
      wait_n(3);
      chk("sb", service_status_byte, 16'h0004);
      err_not_empty = 1'b0;
      $display("t_sbyte done");
   endtask
   task automatic t_esr;
      cmd(ESEW, 8'h08);
      std_event_set = 8'h08;
      wait_n(1);
      std_event_set = 8'h00;
      wait_n(3);
      chk("sb", service_status_byte, 16'h0020);
      rd(ESRR); chk("esr", r, 16'h0008);
      rd(ESRR); chk("esr", r, 16'h0000);
      chk("sb", service_status_byte, 16'h0000);
      $display("t_esr done");
   endtask
   task automatic t_opc;
      exec_busy = 1'b1;
      cmd(OPC, 8'h00);
      wait_n(5);
      rd(ESRR); chk("esr busy", r, 16'h0000);
      exec_busy = 1'b0;
      wait_n(3);
      rd(ESRR); chk("esr", r, 16'h0001);
      exec_busy = 1'b1;
      fork
         rd(OPCR);
         begin
            wait_n(6);
            chk("hold", {15'h0, cmd_hold}, 16'h0001);
            exec_busy = 1'b0;
         end
      join
      chk("opc q", r, 16'h0001);
      $display("t_opc done");
   endtask
   task automatic t_preset;
      grp(1'b1, 4'h0, 3'h3, 16'h0001);
      grp(1'b1, 4'hF, 3'h2, 16'h1234);
      chk("errq en", errq_enable, 16'h1234);
      gr(4'hF, 3'h2); chk("errq q", r, 16'h1234);
      cmd(PRE, 8'h00);
      for (int s = 0; s < 7; s++) begin
         for (int g = 2; g < 5; g++) begin
            gr(s[3:0], g[2:0]);
            chk("preset", r, (s > 1 || g == 3) ? 16'h7FFF : 16'h0000);
         end
      end
      chk("errq en", errq_enable, 16'h0000);
      rd(ESER); chk("ese kept", r, 16'h0008);
      $display("t_preset done");
   endtask
   task automatic t_groups;
      grp(1'b1, 4'h0, 3'h2, 16'h0002);
      oper_cond = 16'h0002;
      wait_n(4);
      chk("sb", service_status_byte, 16'h0080);
      gr(4'h0, 3'h1); chk("event", r, 16'h0002);
      gr(4'h0, 3'h1); chk("event", r, 16'h0000);
      grp(1'b1, 4'h0, 3'h3, 16'h0000);
      grp(1'b1, 4'h0, 3'h4, 16'h0004);
      oper_cond = 16'h8006;
      wait_n(3);
      gr(4'h0, 3'h0); chk("cond", r, 16'h0006);
      gr(4'h0, 3'h1); chk("rise", r, 16'h0000);
      oper_cond = 16'h0000;
      wait_n(3);
      gr(4'h0, 3'h1); chk("fall", r, 16'h0004);
      grp(1'b1, 4'h1, 3'h2, 16'h0001);
      sub_cond = 80'h1;
      err_not_empty = 1'b1;
      std_event_set = 8'h08;
      wait_n(1);
      std_event_set = 8'h00;
      wait_n(6);
      chk("sb", service_status_byte, 16'h002C);
      cmd(CLS, 8'h00);
      err_not_empty = 1'b0; // Queue emptied by the clear pulse
      wait_n(4);
      chk("sb", service_status_byte, 16'h0000);
      rd(ESRR); chk("esr", r, 16'h0000);
      $display("t_groups done");
   endtask

   // Main sequence and a watchdog on the whole run
   initial begin
      t_restore;
      t_enables;
      t_sbyte;
      t_esr;
      t_opc;
      t_preset;
      t_groups;
      report_and_stop;
   end
   initial begin
      #400000;
      failures++;
      report_and_stop;
   end
endmodule
`default_nettype wire

// >>> rtl/status_byte_map.vh
// Bit positions, register codes, reset and preset values of the status block.
// Included by the status byte core and the event group; holds definitions only.
`ifndef STATUS_BYTE_MAP_VH
`define STATUS_BYTE_MAP_VH

// Status byte bit positions
`define SB_ERRQ        2
`define SB_QUES        3
`define SB_MAV         4
`define SB_ESB         5
`define SB_MSS         6
`define SB_OPER        7
`define SB_UNUSED      2'h0

// Standard event status bits
`define ESR_OPC        0

// Group register width and the top bit that reads zero in every group register except the error queue enable
`define GRP_DW         16
`define GRP_TOP        15

// Register codes inside a group
`define GREG_COND      3'h0
`define GREG_EVENT     3'h1
`define GREG_ENABLE    3'h2
`define GREG_PTR       3'h3
`define GREG_NTR       3'h4

// Group selectors
`define GSEL_OPER      4'h0
`define GSEL_QUES      4'h1
`define GSEL_ERRQ      4'hF

// Preset and reset values
`define VAL_ZERO       16'h0000
`define VAL_ALL        16'h7FFF
`define ERRQ_EN_INIT   16'h0000
`define SRE_INIT       8'h00
`define ESE_INIT       8'h00
`define ESR_INIT       8'h00
`define BYTE_ZERO      8'h00

// Enable mask for the service request enable write
`define SRE_WMASK      8'hBF

// Reply of the operation-complete query
`define OPC_REPLY      16'h0001

`endif

// >>> rtl/status_byte_service_request.v
// Status byte and service request core with the standard event,
// operation, questionable and questionable sub-groups.
// Assumes a command parser delivering one decoded strobe per cycle.
//
// Functional notes
// - Clear-status empties error queue and clears all event registers.
// - Event-status-enable mask is writable and readable back.
// - Standard event register query returns contents then clears it.
// - Operation-complete sets event bit 0 once earlier commands finish.
// - Operation-complete query holds new commands, then answers 1.
// - Power-on clear flag clears enables at power on; query returns it.
// - Service request enable is writable and readable back.
// - Status byte query returns the byte and changes nothing.
// - Preset loads operation/questionable filters and sub-group filters.
// - Preset reloads error queue enable, leaves common enables alone.
// - Status byte bits 0 and 1 always read zero.
// - Bit 2 is set while the error queue is not empty.
// - Bit 3 follows the questionable group summary.
// - Bit 4 is set while the output queue holds data.
// - Bit 5 follows the standard event summary.
// - Bit 6 is OR of status byte bits ANDed with enables.
// - Bit 7 follows the operation group summary.
// - Status byte reply is the weighted sum including bit 6.
// - Event registers latch filtered transitions until read or cleared.
// - Group summary is OR of event bits ANDed with enables.
// - Serial poll clears the request-service bit only.
// - Service request enable bit 6 cannot be set.
`timescale 1ns/1ps
`default_nettype none
`include "status_byte_map.vh"

module status_byte_service_request #(
   parameter NSUB = 5
) (
   // Clock, reset, enable
   input  wire                ref_clk,
   input  wire                reset,
   input  wire                clk_en,
   // Power-on restore values
   input  wire                psc_restore,
   input  wire [7:0]          sre_restore,
   input  wire [7:0]          ese_restore,
   // Common command strobes
   input  wire                cls_stb,
   input  wire                ese_wr_stb,
   input  wire                ese_rd_stb,
   input  wire                esr_rd_stb,
   input  wire                opc_stb,
   input  wire                opc_rd_stb,
   input  wire                psc_wr_stb,
   input  wire                psc_rd_stb,
   input  wire                sre_wr_stb,
   input  wire                sre_rd_stb,
   input  wire                stb_rd_stb,
   input  wire                poll_stb,
   input  wire                preset_stb,
   input  wire [7:0]          cmd_data,
   // Group register access
   input  wire                grp_wr_stb,
   input  wire                grp_rd_stb,
   input  wire [3:0]          grp_sel,
   input  wire [2:0]          grp_reg,
   input  wire [15:0]         grp_wr_data,
   // Device state
   input  wire                exec_busy,
   input  wire                err_not_empty,
   input  wire                msg_avail,
   input  wire [7:0]          std_event_set,
   input  wire [15:0]         oper_cond,
   input  wire [15:0]         ques_cond,
   input  wire [16*NSUB-1:0]  sub_cond,
   // Replies
   output reg                 resp_valid,
   output reg  [15:0]         resp_data,
   output reg  [7:0]          poll_byte,
   output reg                 poll_valid,
   // Status and control outputs
   output reg  [7:0]          service_status_byte,
   output reg                 srq,
   output reg                 cmd_hold,
   output reg                 err_queue_clear,
   output reg  [15:0]         errq_enable,
   output reg                 psc_flag
);

   localparam NG = NSUB + 2;

   // Operation-complete query states
   localparam OQ_IDLE = 1'b0;
   localparam OQ_WAIT = 1'b1;

   reg  [7:0]         sre;
   reg  [7:0]         ese;
   reg  [7:0]         esr;
   reg                opc_pend;
   reg                oq_state;
   reg                rqs;
   reg                mss_prev;
   reg  [15:0]        next_resp;
   reg                next_valid;

   wire [16*NG-1:0]   g_cond;
   wire [16*NG-1:0]   g_event;
   wire [16*NG-1:0]   g_enable;
   wire [16*NG-1:0]   g_ptr;
   wire [16*NG-1:0]   g_ntr;
   wire [NG-1:0]      g_sum;
   wire [15:0]        sub_bits;
   wire [7:0]         sbyte;
   wire [7:0]         sbyte_raw;
   wire               esb;
   wire               mss;
   wire               opc_done;

   // One selector decode serves group writes and event read clears; read data uses pick16
   function grp_hit;
      input [3:0] sel;
      input integer idx;
      begin
         grp_hit = (sel == idx[3:0]);
      end
   endfunction

   // Picks one 16-bit register out of a packed group bus
   function [15:0] pick16;
      input [16*NG-1:0] bus;
      input [3:0]       sel;
      integer k;
      begin
         pick16 = `VAL_ZERO;
         for (k = 0; k < NG; k = k + 1)
            if (sel == k[3:0])
               pick16 = bus[16*k +: 16];
      end
   endfunction

   // Sub-group summaries feed the low questionable condition bits
   assign sub_bits = {{(16-NSUB){1'b0}}, g_sum[NG-1:2]};
   assign g_cond[15:0]  = oper_cond;
   assign g_cond[31:16] = ques_cond | sub_bits;
   assign g_cond[16*NG-1:32] = sub_cond;

   genvar gi;
   generate
      for (gi = 0; gi < NG; gi = gi + 1) begin : grp
         wire [15:0] rst_en;
         wire [15:0] pre_en;
         wire [15:0] pre_ntr;
         // Sub-group enables count as device-specific enables
         assign rst_en  = (gi < 2 || psc_restore) ? `VAL_ZERO : `VAL_ALL;
         assign pre_en  = (gi < 2) ? `VAL_ZERO : `VAL_ALL;
         assign pre_ntr = (gi < 2) ? `VAL_ZERO : `VAL_ALL;
         status_event_group u_grp (
            .ref_clk    (ref_clk),
            .reset      (reset),
            .clk_en     (clk_en),
            .cond       (g_cond[16*gi +: 16]),
            .wr_en      (grp_wr_stb && grp_hit(grp_sel, gi)),
            .wr_reg     (grp_reg),
            .wr_data    (grp_wr_data),
            .preset     (preset_stb),
            .clear      (cls_stb),
            .event_rd   (grp_rd_stb && grp_hit(grp_sel, gi) && grp_reg == `GREG_EVENT),
            .rst_enable (rst_en),
            .pre_enable (pre_en),
            .pre_ptr    (`VAL_ALL),
            .pre_ntr    (pre_ntr),
            .event_q    (g_event[16*gi +: 16]),
            .enable_q   (g_enable[16*gi +: 16]),
            .ptr_q      (g_ptr[16*gi +: 16]),
            .ntr_q      (g_ntr[16*gi +: 16]),
            .summary    (g_sum[gi])
         );
      end
   endgenerate

   // Status byte assembly without and with the master summary bit
   assign esb = |(esr & ese);
   assign sbyte_raw = {g_sum[0],
                       1'b0,
                       esb,
                       msg_avail,
                       g_sum[1],
                       err_not_empty,
                       `SB_UNUSED};
   assign mss   = |(sbyte_raw & sre);
   assign sbyte = sbyte_raw | ({7'h00, mss} << `SB_MSS);
   assign opc_done = opc_pend && !exec_busy;

   // Reply selection; parser sends at most one strobe per cycle
   always @* begin
      next_valid = 1'b1;
      next_resp  = `VAL_ZERO;
      if (ese_rd_stb)
         next_resp = {8'h00, ese};
      else if (esr_rd_stb)
         next_resp = {8'h00, esr};
      else if (psc_rd_stb)
         next_resp = {15'h0000, psc_flag};
      else if (sre_rd_stb)
         next_resp = {8'h00, sre};
      else if (stb_rd_stb)
         next_resp = {8'h00, sbyte};
      else if (grp_rd_stb && grp_sel == `GSEL_ERRQ)
         next_resp = errq_enable;
      else if (grp_rd_stb) begin
         case (grp_reg)
            `GREG_COND:   next_resp = pick16(g_cond, grp_sel) & `VAL_ALL;
            `GREG_EVENT:  next_resp = pick16(g_event, grp_sel);
            `GREG_ENABLE: next_resp = pick16(g_enable, grp_sel);
            `GREG_PTR:    next_resp = pick16(g_ptr, grp_sel);
            `GREG_NTR:    next_resp = pick16(g_ntr, grp_sel);
            default:      next_resp = `VAL_ZERO;
         endcase
      end else if (oq_state == OQ_WAIT && !exec_busy)
         next_resp = `OPC_REPLY;
      else
         next_valid = 1'b0;
   end

   // Reply and status byte registers
   always @(posedge ref_clk) begin
      if (reset) begin
         resp_valid          <= 1'b0;
         resp_data           <= `VAL_ZERO;
         service_status_byte <= `BYTE_ZERO;
      end else if (clk_en) begin
         resp_valid          <= next_valid;
         resp_data           <= next_resp;
         service_status_byte <= sbyte;
      end
   end

   // Enable masks; a reset brings them back per the power-on clear flag
   always @(posedge ref_clk) begin
      if (reset) begin
         psc_flag <= psc_restore;
         sre      <= psc_restore ? `SRE_INIT : (sre_restore & `SRE_WMASK);
         ese      <= psc_restore ? `ESE_INIT : ese_restore;
      end else if (clk_en) begin
         if (psc_wr_stb)
            psc_flag <= |cmd_data;
         if (sre_wr_stb)
            sre <= cmd_data & `SRE_WMASK;
         if (ese_wr_stb)
            ese <= cmd_data;
      end
   end

   // Standard event register; new events beat a read or clear
   always @(posedge ref_clk) begin
      if (reset)
         esr <= `ESR_INIT;
      else if (clk_en) begin
         if (cls_stb || esr_rd_stb)
            esr <= std_event_set | ({7'h00, opc_done} << `ESR_OPC);
         else
            esr <= esr | std_event_set | ({7'h00, opc_done} << `ESR_OPC);
      end
   end

   // Operation-complete command waits for the executor to go idle
   always @(posedge ref_clk) begin
      if (reset)
         opc_pend <= 1'b0;
      else if (clk_en) begin
         if (opc_stb)
            opc_pend <= 1'b1;
         else if (opc_done)
            opc_pend <= 1'b0;
      end
   end

   // Operation-complete query holds the parser until work drains
   always @(posedge ref_clk) begin
      if (reset) begin
         oq_state <= OQ_IDLE;
         cmd_hold <= 1'b0;
      end else if (clk_en) begin
         case (oq_state)
            OQ_IDLE: begin
               if (opc_rd_stb) begin
                  oq_state <= OQ_WAIT;
                  cmd_hold <= 1'b1;
               end
            end
            OQ_WAIT: begin
               if (!exec_busy) begin
                  oq_state <= OQ_IDLE;
                  cmd_hold <= 1'b0;
               end
            end
            default: begin
               oq_state <= OQ_IDLE;
               cmd_hold <= 1'b0;
            end
         endcase
      end
   end

   // Request service latch: set on a new reason, cleared by a poll
   always @(posedge ref_clk) begin
      if (reset) begin
         rqs        <= 1'b0;
         mss_prev   <= 1'b0;
         srq        <= 1'b0;
         poll_byte  <= `BYTE_ZERO;
         poll_valid <= 1'b0;
      end else if (clk_en) begin
         mss_prev   <= mss;
         poll_valid <= poll_stb;
         if (poll_stb)
            poll_byte <= {sbyte_raw[7], rqs, sbyte_raw[5:0]};
         // Only one pending request; a new reason beats the poll clear
         if (mss && !mss_prev)
            rqs <= 1'b1;
         else if (poll_stb)
            rqs <= 1'b0;
         srq <= (mss && !mss_prev) || (rqs && !poll_stb);
      end
   end

   // Clear-status empties the error queue; preset reloads its enable
   always @(posedge ref_clk) begin
      if (reset) begin
         err_queue_clear <= 1'b0;
         errq_enable     <= `ERRQ_EN_INIT;
      end else if (clk_en) begin
         err_queue_clear <= cls_stb;
         if (preset_stb)
            errq_enable <= `ERRQ_EN_INIT;
         else if (grp_wr_stb && grp_sel == `GSEL_ERRQ && grp_reg == `GREG_ENABLE)
            errq_enable <= grp_wr_data;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/status_event_group.v
// One status group: condition, transition filters, event latch, enable.
// Assumes single clock, synchronous reset, strobes one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "status_byte_map.vh"

module status_event_group (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        clk_en,
   // Live condition bits
   input  wire [15:0] cond,
   // Register write
   input  wire        wr_en,
   input  wire [2:0]  wr_reg,
   input  wire [15:0] wr_data,
   // Global actions
   input  wire        preset,
   input  wire        clear,
   input  wire        event_rd,
   // Reset and preset values
   input  wire [15:0] rst_enable,
   input  wire [15:0] pre_enable,
   input  wire [15:0] pre_ptr,
   input  wire [15:0] pre_ntr,
   // Register contents
   output reg  [15:0] event_q,
   output reg  [15:0] enable_q,
   output reg  [15:0] ptr_q,
   output reg  [15:0] ntr_q,
   output wire        summary
);

   reg  [15:0] cond_prev;
   reg         primed;
   wire [15:0] rise;
   wire [15:0] fall;
   wire [15:0] hits;
   wire [15:0] used;

   // Top bit never stores anything
   assign used    = `VAL_ALL;
   assign rise    = cond & ~cond_prev & ptr_q;
   assign fall    = ~cond & cond_prev & ntr_q;
   assign hits    = (rise | fall) & used;
   assign summary = |(event_q & enable_q);

   // Event latch; a fresh transition beats a read or clear in the same cycle
   always @(posedge ref_clk) begin
      if (reset) begin
         cond_prev <= `VAL_ZERO;
         primed    <= 1'b0;
         event_q   <= `VAL_ZERO;
      end else if (clk_en) begin
         cond_prev <= cond;
         primed    <= 1'b1;
         if (!primed)
            event_q <= `VAL_ZERO;   // No false edge from reset state
         else if (clear || event_rd)
            event_q <= hits;
         else
            event_q <= event_q | hits;
      end
   end

   // Filters and enable; preset overrides a write in the same cycle
   always @(posedge ref_clk) begin
      if (reset) begin
         enable_q <= rst_enable;
         ptr_q    <= `VAL_ALL;
         ntr_q    <= `VAL_ZERO;
      end else if (clk_en) begin
         if (preset) begin
            enable_q <= pre_enable;
            ptr_q    <= pre_ptr;
            ntr_q    <= pre_ntr;
         end else if (wr_en) begin
            case (wr_reg)
               `GREG_ENABLE: enable_q <= wr_data & used;
               `GREG_PTR:    ptr_q    <= wr_data & used;
               `GREG_NTR:    ntr_q    <= wr_data & used;
               default:      enable_q <= enable_q;
            endcase
         end
      end
   end

endmodule
`default_nettype wire
